// ### core/tpwm_core.sv
// tpwm_core: 16-bit timer channel in pwm output mode behind an apb slave
// assumes apb master on pclk; pins drive an external load
// Behaviour
// [R01] mode field 100 selects pwm
// [R02] run bit clears counter ffff to 0000
// [R03] toggle pin flips once per period
// [R04] active width equals duty shadow
// [R05] period is period shadow plus one
// [R06] compare rewrites apply at counter clear
// [R07] period irq coincides with clear
// [R08] duty irq when counter equals duty
// [R09] duty write arms the shadow transfer
// [R10] software writes period before duty
// [R11] period-only change rewrites duty too
// [R12] duty-only change writes duty only
// [R13] software updates after duty irq
// [R14] no rewrite until period irq
// [R15] duty zero gives inactive output
// [R16] duty period plus one full-on
// [R17] counter readback without disturbing count
// [R18] edge select holds two-bit field
// [R19] capture and option registers ignored
// [R20] setup before starting counter
// [R21] run bit and clock select field
// [R22] polarity and enable of pwm pin
// [R23] idle level of disabled toggle pin
// [R24] active from clear to duty match
// [R25] stopped counter holds ffff
//
// The APB slave port and the placing of the registers were left to the implementer.
module tpwm_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             pwm_out_pin,
  output logic             pwm_out_oe_n,
  output logic             half_rate_toggle_pin,
  output logic             toggle_oe_n,
  output logic             period_match_irq,
  output logic             duty_match_irq
);
  logic [7:0]  run_ctrl_q, run_ctrl_d;
  logic [2:0]  mode_ctrl_q, mode_ctrl_d;
  logic [3:0]  out_ctrl_q, out_ctrl_d;
  logic [7:0]  capt_edge_q, capt_edge_d;
  logic [7:0]  edge_sel_q, edge_sel_d;
  logic [7:0]  option_q, option_d;
  logic [15:0] period_q, period_d;
  logic [15:0] duty_q, duty_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] per_sh_q, per_sh_d;
  logic [15:0] duty_sh_q, duty_sh_d;
  logic        armed_q, armed_d;
  logic        act_q, act_d;
  logic        tog_q, tog_d;
  logic        running_q, running_d;
  logic        pirq_q, pirq_d;
  logic        dirq_q, dirq_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        perr_q, perr_d;
  tpwm_pkg::tpwm_pins_t pins_q, pins_d;
  logic        tick;
  logic        wr_acc;
  logic        rd_acc;
  logic        pwm_mode;
  logic        run_en;
  logic        clear_evt;
  logic        acc_first;
  logic [15:0] duty_next;

  // one wait state: answer registered in the first access cycle, the
  // write lands at the edge where the master sees pready high
  assign acc_first = psel && penable && !pready_q;
  assign wr_acc    = psel && penable && pwrite && pready_q;
  assign rd_acc    = acc_first && !pwrite;
  // [R01] mode decode gate
  assign pwm_mode = mode_ctrl_q == tpwm_pkg::MODE_PWM;
  // [R21] run bit enables
  assign run_en = run_ctrl_q[tpwm_pkg::RUN_BIT] && pwm_mode;
  // [R05] clear after period
  assign clear_evt = running_q && tick && cnt_q == per_sh_q;
  // duty value in force after a clear
  assign duty_next = armed_q ? duty_q : duty_sh_q;

  tpwm_prescale u_prescale (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run_en),
    .sel     (run_ctrl_q[tpwm_pkg::CKS_LSB +: 3]),
    .tick    (tick)
  );

  // register file
  always_comb begin
    run_ctrl_d  = run_ctrl_q;
    mode_ctrl_d = mode_ctrl_q;
    out_ctrl_d  = out_ctrl_q;
    capt_edge_d = capt_edge_q;
    edge_sel_d  = edge_sel_q;
    option_d    = option_q;
    period_d    = period_q;
    duty_d      = duty_q;
    prdata_d    = 32'h0000_0000;
    perr_d      = 1'b0;
    pready_d    = acc_first;
    // error flag must stand with pready, so decode in the first access
    if (acc_first) begin
      case (paddr)
        tpwm_pkg::ADDR_RUN_CTRL, tpwm_pkg::ADDR_MODE_CTRL,
        tpwm_pkg::ADDR_OUT_CTRL, tpwm_pkg::ADDR_CAPT_EDGE,
        tpwm_pkg::ADDR_EDGE_SEL, tpwm_pkg::ADDR_OPTION,
        tpwm_pkg::ADDR_COUNTER, tpwm_pkg::ADDR_PERIOD,
        tpwm_pkg::ADDR_DUTY, tpwm_pkg::ADDR_STATUS: perr_d = 1'b0;
        default: perr_d = 1'b1;
      endcase
    end
    if (wr_acc) begin
      case (paddr)
        tpwm_pkg::ADDR_RUN_CTRL:  run_ctrl_d  = pwdata[7:0] & 8'h87;
        tpwm_pkg::ADDR_MODE_CTRL: mode_ctrl_d = pwdata[2:0];
        tpwm_pkg::ADDR_OUT_CTRL:  out_ctrl_d  = pwdata[3:0];
        // [R19] stored, not used
        tpwm_pkg::ADDR_CAPT_EDGE: capt_edge_d = pwdata[7:0];
        // [R18] trigger field zero
        tpwm_pkg::ADDR_EDGE_SEL:
          edge_sel_d = pwdata[7:0] & tpwm_pkg::EDGE_SEL_MASK;
        tpwm_pkg::ADDR_OPTION:    option_d    = pwdata[7:0];
        tpwm_pkg::ADDR_PERIOD:    period_d    = pwdata[15:0];
        tpwm_pkg::ADDR_DUTY:      duty_d      = pwdata[15:0];
        // read-only and unmapped offsets keep all state
        default:                  perr_d      = 1'b0;
      endcase
    end
    if (rd_acc) begin
      case (paddr)
        tpwm_pkg::ADDR_RUN_CTRL:  prdata_d = {24'h0, run_ctrl_q};
        tpwm_pkg::ADDR_MODE_CTRL: prdata_d = {29'h0, mode_ctrl_q};
        tpwm_pkg::ADDR_OUT_CTRL:  prdata_d = {28'h0, out_ctrl_q};
        tpwm_pkg::ADDR_CAPT_EDGE: prdata_d = {24'h0, capt_edge_q};
        tpwm_pkg::ADDR_EDGE_SEL:  prdata_d = {24'h0, edge_sel_q};
        tpwm_pkg::ADDR_OPTION:    prdata_d = {24'h0, option_q};
        // [R17] live counter read
        tpwm_pkg::ADDR_COUNTER:   prdata_d = {16'h0, cnt_q};
        tpwm_pkg::ADDR_PERIOD:    prdata_d = {16'h0, period_q};
        tpwm_pkg::ADDR_DUTY:      prdata_d = {16'h0, duty_q};
        tpwm_pkg::ADDR_STATUS:
          prdata_d = {28'h0, armed_q, running_q, act_q, tog_q};
        default:                  perr_d   = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ctrl_q  <= tpwm_pkg::REG8_RESET;
      mode_ctrl_q <= 3'h0;
      out_ctrl_q  <= 4'h0;
      capt_edge_q <= tpwm_pkg::REG8_RESET;
      edge_sel_q  <= tpwm_pkg::REG8_RESET;
      option_q    <= tpwm_pkg::REG8_RESET;
      period_q    <= tpwm_pkg::CMP_RESET;
      duty_q      <= tpwm_pkg::CMP_RESET;
      prdata_q    <= 32'h0000_0000;
      pready_q    <= 1'b0;
      perr_q      <= 1'b0;
    end else begin
      run_ctrl_q  <= run_ctrl_d;
      mode_ctrl_q <= mode_ctrl_d;
      out_ctrl_q  <= out_ctrl_d;
      capt_edge_q <= capt_edge_d;
      edge_sel_q  <= edge_sel_d;
      option_q    <= option_d;
      period_q    <= period_d;
      duty_q      <= duty_d;
      prdata_q    <= prdata_d;
      pready_q    <= pready_d;
      perr_q      <= perr_d;
    end
  end

  // counter, shadows and waveform
  always_comb begin
    cnt_d     = cnt_q;
    per_sh_d  = per_sh_q;
    duty_sh_d = duty_sh_q;
    armed_d   = armed_q;
    act_d     = act_q;
    tog_d     = tog_q;
    running_d = running_q;
    pirq_d    = 1'b0;
    dirq_d    = 1'b0;
    // [R09] duty write arms
    if (wr_acc && paddr == tpwm_pkg::ADDR_DUTY) begin
      armed_d = 1'b1;
    end
    if (!run_en) begin
      // [R25] idle at ffff
      cnt_d     = tpwm_pkg::CNT_IDLE;
      running_d = 1'b0;
      act_d     = 1'b0;
      armed_d   = 1'b0;
    end else if (!running_q) begin
      // [R02] start from ffff
      if (tick) begin
        running_d = 1'b1;
        cnt_d     = tpwm_pkg::CNT_ZERO;
        // [R20] shadows load directly
        per_sh_d  = period_q;
        duty_sh_d = duty_q;
        // [R15] zero duty never active
        act_d     = duty_q != tpwm_pkg::CMP_RESET;
        dirq_d    = duty_q == tpwm_pkg::CMP_RESET;
        armed_d   = 1'b0;
      end
    end else if (tick) begin
      if (clear_evt) begin
        cnt_d  = tpwm_pkg::CNT_ZERO;
        // [R07] irq with clear
        pirq_d = 1'b1;
        // [R03] toggle per period
        tog_d  = !tog_q;
        // [R06] transfer at clear
        if (armed_q) begin
          per_sh_d  = period_q;
          duty_sh_d = duty_q;
          // [R14] duty write in clear cycle re-arms
          armed_d   = wr_acc && paddr == tpwm_pkg::ADDR_DUTY;
        end
        // [R24] active from zero
        act_d  = duty_next != tpwm_pkg::CMP_RESET;
        // [R15] zero duty still matches once per period
        dirq_d = duty_next == tpwm_pkg::CMP_RESET;
      end else begin
        cnt_d = cnt_q + 16'h0001;
        // [R08] duty irq as the count reaches duty
        // [R04] inactive at duty, so width equals duty
        // [R16] duty above period never matches: full on
        if (cnt_d == duty_sh_q) begin
          dirq_d = 1'b1;
          act_d  = 1'b0;
        end
      end
    end
  end

  always_comb begin
    // [R22] polarity and enable
    // pins follow next state so the pin edge lines up with the irq
    pins_d.pwm      = act_d ^ out_ctrl_q[tpwm_pkg::OL_PWM_BIT];
    pins_d.pwm_oe_n = !out_ctrl_q[tpwm_pkg::OE_PWM_BIT];
    // [R23] idle level when disabled
    pins_d.tog      = out_ctrl_q[tpwm_pkg::OE_TOG_BIT]
                      ? (tog_d ^ out_ctrl_q[tpwm_pkg::OL_TOG_BIT])
                      : out_ctrl_q[tpwm_pkg::OL_TOG_BIT];
    pins_d.tog_oe_n = !out_ctrl_q[tpwm_pkg::OE_TOG_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= tpwm_pkg::CNT_IDLE;
      per_sh_q  <= tpwm_pkg::CMP_RESET;
      duty_sh_q <= tpwm_pkg::CMP_RESET;
      armed_q   <= 1'b0;
      act_q     <= 1'b0;
      tog_q     <= 1'b0;
      running_q <= 1'b0;
      pirq_q    <= 1'b0;
      dirq_q    <= 1'b0;
      pins_q    <= '0;
    end else begin
      cnt_q     <= cnt_d;
      per_sh_q  <= per_sh_d;
      duty_sh_q <= duty_sh_d;
      armed_q   <= armed_d;
      act_q     <= act_d;
      tog_q     <= tog_d;
      running_q <= running_d;
      pirq_q    <= pirq_d;
      dirq_q    <= dirq_d;
      pins_q    <= pins_d;
    end
  end

  assign prdata               = prdata_q;
  assign pready               = pready_q;
  assign pslverr              = perr_q;
  assign pwm_out_pin          = pins_q.pwm;
  assign pwm_out_oe_n         = pins_q.pwm_oe_n;
  assign half_rate_toggle_pin = pins_q.tog;
  assign toggle_oe_n          = pins_q.tog_oe_n;
  assign period_match_irq     = pirq_q;
  assign duty_match_irq       = dirq_q;

  // [R07] period irq with zero
  AST_PIRQ_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    pirq_q |-> cnt_q == tpwm_pkg::CNT_ZERO) // [R07]
    else $error("period irq without counter clear");
  // [R25] stopped counter idles
  AST_IDLE_FFFF: assert property (@(posedge pclk) disable iff (!presetn)
    !run_en ##1 !run_en |-> cnt_q == tpwm_pkg::CNT_IDLE) // [R25]
    else $error("stopped counter not at ffff");
  // [R05] clear follows period
  AST_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    clear_evt && run_en |=> cnt_q == tpwm_pkg::CNT_ZERO) // [R05]
    else $error("counter did not clear at period");
  // [R08] duty irq on match
  AST_DIRQ: assert property (@(posedge pclk) disable iff (!presetn)
    dirq_q |-> cnt_q == duty_sh_q) // [R08]
    else $error("duty irq away from duty match");
  // [R08] match raises irq at once
  AST_DIRQ_HIT: assert property (@(posedge pclk) disable iff (!presetn)
    running_q && cnt_q == duty_sh_q && $changed(cnt_q) |-> dirq_q) // [R08]
    else $error("duty irq missing");
  // [R03] toggle flips at clear
  AST_TOG: assert property (@(posedge pclk) disable iff (!presetn)
    pirq_q |-> tog_q != $past(tog_q)) // [R03]
    else $error("toggle did not flip");
  // [R15] duty zero stays inactive
  AST_ZERO_DUTY: assert property (@(posedge pclk) disable iff (!presetn)
    running_q && duty_sh_q == tpwm_pkg::CMP_RESET && !armed_q
    && $stable(duty_sh_q) |=> !act_q) // [R15]
    else $error("zero duty went active");
  // [R09] period shadow stays without arm
  AST_NO_ARM: assert property (@(posedge pclk) disable iff (!presetn)
    running_q && run_en && !armed_q |=> $stable(per_sh_q)) // [R09]
    else $error("shadow loaded without arm");
  // [R22] enable drives pin
  AST_OE: assert property (@(posedge pclk) disable iff (!presetn)
    out_ctrl_q[tpwm_pkg::OE_PWM_BIT] |=> !pwm_out_oe_n) // [R22]
    else $error("pwm pin not driven");
  COV_PIRQ: cover property (@(posedge pclk) disable iff (!presetn) pirq_q);
  COV_DIRQ: cover property (@(posedge pclk) disable iff (!presetn) dirq_q);
  COV_LOAD: cover property (@(posedge pclk) disable iff (!presetn)
    armed_q && clear_evt);
  COV_ZERO: cover property (@(posedge pclk) disable iff (!presetn)
    pirq_q && dirq_q);
endmodule : tpwm_core

// ### core/tpwm_pkg.sv
// tpwm_pkg: register map, field positions and reset values of the pwm timer
// assumes an apb slave with 32-bit data, one register per aligned word
package tpwm_pkg;
  localparam logic [7:0]  ADDR_RUN_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_MODE_CTRL   = 8'h04;
  localparam logic [7:0]  ADDR_OUT_CTRL    = 8'h08;
  localparam logic [7:0]  ADDR_CAPT_EDGE   = 8'h0c;
  localparam logic [7:0]  ADDR_EDGE_SEL    = 8'h10;
  localparam logic [7:0]  ADDR_OPTION      = 8'h14;
  localparam logic [7:0]  ADDR_COUNTER     = 8'h18;
  localparam logic [7:0]  ADDR_PERIOD      = 8'h1c;
  localparam logic [7:0]  ADDR_DUTY        = 8'h20;
  localparam logic [7:0]  ADDR_STATUS      = 8'h24;

  localparam int          RUN_BIT          = 7;
  localparam int          CKS_LSB          = 0;
  localparam int          OE_TOG_BIT       = 0;
  localparam int          OL_TOG_BIT       = 1;
  localparam int          OE_PWM_BIT       = 2;
  localparam int          OL_PWM_BIT       = 3;
  localparam int          EES_LSB          = 2;

  localparam logic [2:0]  MODE_PWM         = 3'h4;
  localparam logic [7:0]  EDGE_SEL_MASK    = 8'h0c;
  localparam logic [15:0] CNT_IDLE         = 16'hffff;
  localparam logic [15:0] CNT_ZERO         = 16'h0000;
  localparam logic [15:0] CMP_RESET        = 16'h0000;
  localparam logic [7:0]  REG8_RESET       = 8'h00;

  // pin outputs travel together
  typedef struct packed {
    logic pwm;
    logic tog;
    logic pwm_oe_n;
    logic tog_oe_n;
  } tpwm_pins_t;
endpackage : tpwm_pkg

// ### core/tpwm_prescale.sv
// tpwm_prescale: count clock enable from pclk divided by 2^sel
// assumes sel is static while the counter runs
module tpwm_prescale (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output logic            tick
);
  logic [7:0] div_q;
  logic [7:0] div_d;
  logic       tick_d;

  always_comb begin
    div_d  = run ? div_q + 8'h01 : 8'h00;
    tick_d = 1'b0;
    if (run) begin
      if (sel == 3'h0) begin
        tick_d = 1'b1;
      end else begin
        tick_d = (div_q & ((8'h01 << sel) - 8'h01)) == 8'h00;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_d;
    end
  end

  assign tick = tick_d;
endmodule : tpwm_prescale

// ### verification/tpwm_load_model.sv
// tpwm_load_model: load on the pwm pin, measures the wire level
// assumes a pull-down on the wire, sampled on pclk
module tpwm_load_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pin,
  input  wire logic        oe_n,
  output logic      [31:0] period_cyc,
  output logic      [31:0] high_cyc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        lvl, lvl_q;
  logic [31:0] run_q, hi_q;
  // a released pin falls to the pull-down level
  assign lvl = oe_n ? 1'b0 : pin;
  // width and period latched at each rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q      <= 1'b0;
      run_q      <= 32'h0;
      hi_q       <= 32'h0;
      period_cyc <= 32'h0;
      high_cyc   <= 32'h0;
    end else begin
      lvl_q <= lvl;
      if (lvl && !lvl_q) begin
        period_cyc <= run_q;
        high_cyc   <= hi_q;
        run_q      <= 32'h1;
        hi_q       <= 32'h1;
      end else begin
        run_q <= run_q + 32'h1;
        hi_q  <= hi_q + {31'h0, lvl};
      end
    end
  end
endmodule : tpwm_load_model

// ### verification/tb.sv
// tb: apb sequences on the pwm timer, pin timing seen through a load
// assumes clock select 0 (one tick per pclk) except in the slow run
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        pwm_pin, pwm_oe_n, tog_pin, tog_oe_n, p_irq, d_irq, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, per_cyc, hi_cyc, rd;
  int          failures, checks_done, cycles, hi, tg, pi, di;

  tpwm_core u_tpwm_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_out_pin(pwm_pin), .pwm_out_oe_n(pwm_oe_n),
    .half_rate_toggle_pin(tog_pin), .toggle_oe_n(tog_oe_n),
    .period_match_irq(p_irq), .duty_match_irq(d_irq));
  tpwm_load_model u_tpwm_load_model (.pclk(pclk), .presetn(presetn),
    .pin(pwm_pin), .oe_n(pwm_oe_n), .period_cyc(per_cyc),
    .high_cyc(hi_cyc));

  always #2.5 pclk = ~pclk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // a hung handshake ends the run as a failure
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no limit of its own: pready high or the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(what, e, rd);
  endtask : rdchk

  // software waits for the duty match before touching compares
  task automatic wait_d();
    do begin
      @(posedge pclk);
    end while (d_irq !== 1'b1);
  endtask : wait_d

  // full duty never matches, so wait for the period match instead
  task automatic wait_p();
    do begin
      @(posedge pclk);
    end while (p_irq !== 1'b1);
  endtask : wait_p

  task automatic watch(input int n);
    logic tq;
    hi = 0;
    tg = 0;
    pi = 0;
    di = 0;
    tq = tog_pin;
    repeat (n) begin
      @(posedge pclk);
      hi += (pwm_pin === 1'b1);
      tg += (tog_pin !== tq);
      tq = tog_pin;
      pi += (p_irq === 1'b1);
      di += (d_irq === 1'b1);
    end
  endtask : watch

  initial begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("counter", tpwm_pkg::ADDR_COUNTER, 32'h0000ffff);
    rdchk("period", tpwm_pkg::ADDR_PERIOD, 32'h0);
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    apb(1'b1, tpwm_pkg::ADDR_EDGE_SEL, 32'h000000ff);
    rdchk("edge sel", tpwm_pkg::ADDR_EDGE_SEL, 32'h0000000c);
    // full setup before the run bit
    apb(1'b1, tpwm_pkg::ADDR_MODE_CTRL, 32'h4);
    apb(1'b1, tpwm_pkg::ADDR_OUT_CTRL, 32'h5);
    apb(1'b1, tpwm_pkg::ADDR_PERIOD, 32'h9);
    apb(1'b1, tpwm_pkg::ADDR_DUTY, 32'h3);
    apb(1'b1, tpwm_pkg::ADDR_RUN_CTRL, 32'h80);
    repeat (40) @(posedge pclk);
    chk("period", 32'd10, per_cyc);
    chk("width", 32'd3, hi_cyc);
    watch(40);
    chk("toggles", 32'd4, tg);
    chk("period irqs", 32'd4, pi);
    chk("duty irqs", 32'd4, di);
    chk("oe", 32'h0, {31'h0, pwm_oe_n});
    apb(1'b0, tpwm_pkg::ADDR_COUNTER, 32'h0);
    chk("count range", 32'h1, {31'h0, rd <= 32'h9});
    apb(1'b1, tpwm_pkg::ADDR_CAPT_EDGE, 32'hff);
    apb(1'b1, tpwm_pkg::ADDR_OPTION, 32'hff);
    wait_d();
    apb(1'b1, tpwm_pkg::ADDR_DUTY, 32'h5);
    wait_d();
    apb(1'b1, tpwm_pkg::ADDR_PERIOD, 32'he);
    repeat (40) @(posedge pclk);
    chk("unarmed period", 32'd10, per_cyc);
    chk("new width", 32'd5, hi_cyc);
    wait_d();
    apb(1'b1, tpwm_pkg::ADDR_DUTY, 32'h5);
    repeat (45) @(posedge pclk);
    chk("armed period", 32'd15, per_cyc);
    wait_d();
    apb(1'b1, tpwm_pkg::ADDR_DUTY, 32'h0);
    repeat (45) @(posedge pclk);
    watch(45);
    chk("zero width", 32'd0, hi);
    chk("zero duty irqs", 32'd3, di);
    apb(1'b1, tpwm_pkg::ADDR_DUTY, 32'hf);
    repeat (45) @(posedge pclk);
    watch(45);
    chk("full width", 32'd45, hi);
    wait_p();
    apb(1'b1, tpwm_pkg::ADDR_DUTY, 32'h5);
    apb(1'b1, tpwm_pkg::ADDR_OUT_CTRL, 32'hd);
    repeat (45) @(posedge pclk);
    watch(45);
    chk("low active", 32'd30, hi);
    apb(1'b1, tpwm_pkg::ADDR_RUN_CTRL, 32'h0);
    rdchk("stopped", tpwm_pkg::ADDR_COUNTER, 32'h0000ffff);
    apb(1'b1, tpwm_pkg::ADDR_OUT_CTRL, 32'h6);
    repeat (2) @(posedge pclk);
    chk("tog idle", 32'h3, {30'h0, tog_pin, tog_oe_n});
    apb(1'b1, tpwm_pkg::ADDR_RUN_CTRL, 32'h81);
    repeat (80) @(posedge pclk);
    chk("slow period", 32'd30, per_cyc);
    chk("slow width", 32'd10, hi_cyc);
    apb(1'b1, tpwm_pkg::ADDR_MODE_CTRL, 32'h5);
    rdchk("other mode", tpwm_pkg::ADDR_COUNTER, 32'h0000ffff);
    close_out();
  end
endmodule : tb
